// >>> core/atcs_pkg.sv
// Constants, register map and carrier types of the analog torque command block.
package atcs_pkg;
  localparam int unsigned CLK_HZ      = 250_000_000;
  localparam int unsigned HOLD_MS     = 1000;
  localparam int unsigned HOLD_CYC    = CLK_HZ / 1000 * HOLD_MS;
  localparam int unsigned AUTO_LOG2   = 4;

  localparam logic [7:0] OFS_METHOD   = 8'h00;
  localparam logic [7:0] OFS_OPTION   = 8'h04;
  localparam logic [7:0] OFS_TRQ_GAIN = 8'h08;
  localparam logic [7:0] OFS_SPD_LIM  = 8'h0C;
  localparam logic [7:0] OFS_SPD_GAIN = 8'h10;
  localparam logic [7:0] OFS_MAX_SPD  = 8'h14;
  localparam logic [7:0] OFS_OFFSET   = 8'h18;
  localparam logic [7:0] OFS_CMD      = 8'h1C;
  localparam logic [7:0] OFS_STATUS   = 8'h20;
  localparam logic [7:0] OFS_TRQ_MON  = 8'h24;
  localparam logic [7:0] OFS_FB_GAIN  = 8'h28;

  localparam logic [15:0] METHOD_RST   = 16'h0020;
  localparam logic [15:0] OPTION_RST   = 16'h0000;
  localparam logic [15:0] TRQ_GAIN_RST = 16'h001E;
  localparam logic [15:0] SPD_LIM_RST  = 16'h05DC;
  localparam logic [15:0] SPD_GAIN_RST = 16'h0096;
  localparam logic [15:0] MAX_SPD_RST  = 16'h1770;
  localparam logic [15:0] FB_GAIN_RST  = 16'h0010;
  localparam logic [15:0] TRQ_GAIN_MIN = 16'h000A;
  localparam logic [15:0] TRQ_GAIN_MAX = 16'h0064;
  localparam logic [15:0] SPD_LIM_MAX  = 16'h1770;
  localparam logic [15:0] SPD_GAIN_MAX = 16'h0BB8;

  localparam int unsigned CMD_AUTO_BIT  = 0;
  localparam int unsigned CMD_CLR_BIT   = 1;
  localparam int unsigned LIM_SRC_BIT   = 8;
  localparam logic [3:0]  MODE_TORQUE   = 4'h2;

  typedef struct packed {
    logic               valid;
    logic signed [15:0] mv;
  } atcs_sample_t;

  typedef struct packed {
    logic set;
    logic up;
    logic down;
  } atcs_keys_t;

  typedef struct packed {
    logic limiting;
    logic torque_mode;
    logic editing;
    logic offset_done;
    logic offset_busy;
  } atcs_status_t;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_AUTO  = 5'b00010,
    ST_ENTER = 5'b00100,
    ST_EDIT  = 5'b01000,
    ST_LEAVE = 5'b10000
  } atcs_state_t;
endpackage

// >>> core/atcs_top.sv
// Analog torque command path with offset adjustment, speed limit and APB registers.
`timescale 1ns/1ps
`default_nettype none

module atcs_top #(
  parameter int unsigned HOLD_CYC = atcs_pkg::HOLD_CYC
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire atcs_pkg::atcs_sample_t trq_sample,
  input  wire atcs_pkg::atcs_sample_t lim_sample,
  input  wire logic signed [15:0]     motor_speed,
  input  wire logic                   servo_on_pin,
  input  wire atcs_pkg::atcs_keys_t   keys_pin,
  output logic signed [15:0]          torque_ref,
  output logic                        torque_ref_valid,
  output logic [15:0]                 speed_limit,
  output atcs_pkg::atcs_status_t      status
);

  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                        input logic [15:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic [15:0] umin(input logic [15:0] a, input logic [15:0] b);
    umin = (a < b) ? a : b;
  endfunction

  function automatic logic [15:0] mag(input logic signed [15:0] v);
    mag = v[15] ? 16'(-v) : 16'(v);
  endfunction

  // Pin synchronisers; only the second stage is read.
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
    end else begin
      sync1_r <= {servo_on_pin, keys_pin};
      sync2_r <= sync1_r;
    end
  end
  logic servo_on;
  atcs_pkg::atcs_keys_t keys;
  logic [2:0] keys_d_r;
  assign servo_on = sync2_r[3];
  assign keys     = sync2_r[2:0];
  always_ff @(posedge clk) begin
    if (rst) keys_d_r <= 3'h0;
    else     keys_d_r <= keys;
  end

  // Register file and APB slave.
  logic [15:0] method_r, option_r, tgain_r, slim_r, sgain_r, maxspd_r, fbgain_r;
  logic [15:0] method_nxt, option_nxt, tgain_nxt, slim_nxt, sgain_nxt, maxspd_nxt, fbgain_nxt;
  logic        pready_nxt, pslverr_nxt;
  logic [31:0] prdata_nxt;
  logic        acc, wr, hit, auto_go, done_clr;
  logic signed [15:0] offset_r, offset_nxt;
  logic        done_r, done_nxt;
  atcs_pkg::atcs_state_t st_r, st_nxt;

  assign acc = psel && penable && !pready;
  // A write lands at the edge that completes the access, where pready is sampled high.
  assign wr  = psel && penable && pready && pwrite;

  always_comb begin
    method_nxt  = method_r;
    option_nxt  = option_r;
    tgain_nxt   = tgain_r;
    slim_nxt    = slim_r;
    sgain_nxt   = sgain_r;
    maxspd_nxt  = maxspd_r;
    fbgain_nxt  = fbgain_r;
    prdata_nxt  = 32'h0000_0000;
    pready_nxt  = acc;
    hit         = 1'b1;
    auto_go     = 1'b0;
    done_clr    = 1'b0;
    case (paddr)
      atcs_pkg::OFS_METHOD:   prdata_nxt = {16'h0000, method_r};
      atcs_pkg::OFS_OPTION:   prdata_nxt = {16'h0000, option_r};
      atcs_pkg::OFS_TRQ_GAIN: prdata_nxt = {16'h0000, tgain_r};
      atcs_pkg::OFS_SPD_LIM:  prdata_nxt = {16'h0000, slim_r};
      atcs_pkg::OFS_SPD_GAIN: prdata_nxt = {16'h0000, sgain_r};
      atcs_pkg::OFS_MAX_SPD:  prdata_nxt = {16'h0000, maxspd_r};
      atcs_pkg::OFS_OFFSET:   prdata_nxt = {16'h0000, offset_r};
      atcs_pkg::OFS_CMD:      prdata_nxt = 32'h0000_0000;
      atcs_pkg::OFS_STATUS:   prdata_nxt = {27'h000_0000, status};
      atcs_pkg::OFS_TRQ_MON:  prdata_nxt = {16'h0000, torque_ref};
      atcs_pkg::OFS_FB_GAIN:  prdata_nxt = {16'h0000, fbgain_r};
      default:                hit = 1'b0;
    endcase
    if (!acc || pwrite) prdata_nxt = 32'h0000_0000;
    pslverr_nxt = acc && !hit;
    if (wr) begin
      case (paddr)
        atcs_pkg::OFS_METHOD:   method_nxt = pwdata[15:0];
        atcs_pkg::OFS_OPTION:   option_nxt = pwdata[15:0];
        atcs_pkg::OFS_TRQ_GAIN: tgain_nxt  = clamp(pwdata[15:0], atcs_pkg::TRQ_GAIN_MIN,
                                                   atcs_pkg::TRQ_GAIN_MAX);
        atcs_pkg::OFS_SPD_LIM:  slim_nxt   = umin(pwdata[15:0], atcs_pkg::SPD_LIM_MAX);
        atcs_pkg::OFS_SPD_GAIN: sgain_nxt  = umin(pwdata[15:0], atcs_pkg::SPD_GAIN_MAX);
        atcs_pkg::OFS_MAX_SPD:  maxspd_nxt = pwdata[15:0];
        atcs_pkg::OFS_FB_GAIN:  fbgain_nxt = pwdata[15:0];
        atcs_pkg::OFS_CMD: begin
          auto_go  = pwdata[atcs_pkg::CMD_AUTO_BIT];
          done_clr = pwdata[atcs_pkg::CMD_CLR_BIT];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      method_r <= atcs_pkg::METHOD_RST;
      option_r <= atcs_pkg::OPTION_RST;
      tgain_r  <= atcs_pkg::TRQ_GAIN_RST;
      slim_r   <= atcs_pkg::SPD_LIM_RST;
      sgain_r  <= atcs_pkg::SPD_GAIN_RST;
      maxspd_r <= atcs_pkg::MAX_SPD_RST;
      fbgain_r <= atcs_pkg::FB_GAIN_RST;
      prdata   <= 32'h0000_0000;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
    end else begin
      method_r <= method_nxt;
      option_r <= option_nxt;
      tgain_r  <= tgain_nxt;
      slim_r   <= slim_nxt;
      sgain_r  <= sgain_nxt;
      maxspd_r <= maxspd_nxt;
      fbgain_r <= fbgain_nxt;
      prdata   <= prdata_nxt;
      pready   <= pready_nxt;
      pslverr  <= pslverr_nxt;
    end
  end

  // Offset adjustment: automatic averaging or manual key entry.
  logic signed [19:0] acc_r, acc_nxt;
  logic [4:0]         cnt_r, cnt_nxt;
  logic [31:0]        hold_r, hold_nxt;
  logic signed [15:0] edit_r, edit_nxt;
  logic               up_ev, dn_ev, held;
  logic signed [15:0] avg;
  assign up_ev = keys.up && !keys_d_r[1];
  assign dn_ev = keys.down && !keys_d_r[0];
  assign held  = hold_r >= HOLD_CYC;
  assign avg   = 16'(acc_r >>> atcs_pkg::AUTO_LOG2);

  always_comb begin
    st_nxt     = st_r;
    acc_nxt    = acc_r;
    cnt_nxt    = cnt_r;
    edit_nxt   = edit_r;
    offset_nxt = offset_r;
    done_nxt   = done_r && !done_clr;
    hold_nxt   = keys.set ? (held ? hold_r : hold_r + 32'h0000_0001) : 32'h0000_0000;
    if (wr && paddr == atcs_pkg::OFS_OFFSET) offset_nxt = pwdata[15:0];
    case (st_r)
      atcs_pkg::ST_IDLE: begin
        if (auto_go && !servo_on) begin
          st_nxt  = atcs_pkg::ST_AUTO;
          acc_nxt = 20'sh0_0000;
          cnt_nxt = 5'h00;
        end else if (held) begin
          st_nxt   = atcs_pkg::ST_ENTER;
          edit_nxt = 16'sh0000;
        end
      end
      atcs_pkg::ST_AUTO: begin
        if (trq_sample.valid) begin
          acc_nxt = acc_r + 20'(trq_sample.mv);
          cnt_nxt = cnt_r + 5'h01;
        end
        if (cnt_r[atcs_pkg::AUTO_LOG2]) begin
          offset_nxt = avg;
          done_nxt   = 1'b1;
          st_nxt     = atcs_pkg::ST_IDLE;
        end
      end
      atcs_pkg::ST_ENTER: if (!keys.set) st_nxt = atcs_pkg::ST_EDIT;
      atcs_pkg::ST_EDIT: begin
        if (up_ev)      edit_nxt = edit_r + 16'sh0001;
        else if (dn_ev) edit_nxt = edit_r - 16'sh0001;
        if (held) begin
          offset_nxt = edit_r;
          st_nxt     = atcs_pkg::ST_LEAVE;
        end
      end
      atcs_pkg::ST_LEAVE: if (!keys.set) st_nxt = atcs_pkg::ST_IDLE;
      default: st_nxt = atcs_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r     <= atcs_pkg::ST_IDLE;
      acc_r    <= 20'sh0_0000;
      cnt_r    <= 5'h00;
      hold_r   <= 32'h0000_0000;
      edit_r   <= 16'sh0000;
      offset_r <= 16'sh0000;
      done_r   <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      acc_r    <= acc_nxt;
      cnt_r    <= cnt_nxt;
      hold_r   <= hold_nxt;
      edit_r   <= edit_nxt;
      offset_r <= offset_nxt;
      done_r   <= done_nxt;
    end
  end

  // Torque path. Reference unit is 0.1 % of rated torque, input unit is 1 mV.
  logic [3:0]         mode;
  logic               trq_mode;
  logic signed [21:0] diff, scaled;
  logic signed [15:0] raw, ref_nxt;
  logic [31:0]        ext_lim;
  logic [15:0]        int_lim, lim_nxt, ext_lim_r, ext_lim_nxt, over;
  logic signed [31:0] fb;
  logic               limiting_nxt;
  logic signed [15:0] ref_r;
  logic               valid_r;
  logic [15:0]        lim_r;
  atcs_pkg::atcs_status_t status_r, status_nxt;

  assign mode     = method_r[7:4];
  assign trq_mode = (mode == 4'h2) || (mode == 4'h6) ||
                    (mode == 4'h8) || (mode == 4'h9);
  assign diff     = 22'(trq_sample.mv) - 22'(offset_r);
  // Gain step is 0.1 V, so rated voltage in mV is gain*100 and ref = diff*10/gain.
  assign scaled   = (diff * 22'sd10) / $signed({6'h00, tgain_r});
  assign raw      = (scaled > 22'sd32767) ? 16'sh7FFF :
                    ((scaled < -22'sd32767) ? -16'sh7FFF : 16'(scaled));
  assign ext_lim  = 32'(mag(lim_sample.mv)) * 32'(sgain_r) / 32'd1000;
  assign int_lim  = umin(slim_r, maxspd_r);

  always_comb begin
    ext_lim_nxt = ext_lim_r;
    if (lim_sample.valid) ext_lim_nxt = (ext_lim > 32'h0000_FFFF) ? 16'hFFFF : ext_lim[15:0];
    lim_nxt = option_r[atcs_pkg::LIM_SRC_BIT] ? umin(ext_lim_r, int_lim) : int_lim;
    over    = (mag(motor_speed) > lim_r) ? (mag(motor_speed) - lim_r) : 16'h0000;
    // Proportional pull-back only; the steady speed depends on load, as expected.
    fb      = (32'(over) * 32'(fbgain_r)) >>> 4;
    limiting_nxt = over != 16'h0000;
    ref_nxt = ref_r;
    if (trq_sample.valid) begin
      if (!trq_mode) ref_nxt = 16'sh0000;
      else if (!limiting_nxt) ref_nxt = raw;
      else if (motor_speed[15])
        ref_nxt = (32'(raw) + fb > 32'sd32767) ? 16'sh7FFF : 16'(32'(raw) + fb);
      else
        ref_nxt = (32'(raw) - fb < -32'sd32767) ? -16'sh7FFF : 16'(32'(raw) - fb);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ref_r      <= 16'sh0000;
      valid_r    <= 1'b0;
      lim_r      <= atcs_pkg::SPD_LIM_RST;
      ext_lim_r  <= 16'h0000;
      status_r   <= '0;
    end else begin
      ref_r      <= ref_nxt;
      valid_r    <= trq_sample.valid;
      lim_r      <= lim_nxt;
      ext_lim_r  <= ext_lim_nxt;
      status_r   <= status_nxt;
    end
  end

  assign torque_ref         = ref_r;
  assign torque_ref_valid   = valid_r;
  assign speed_limit        = lim_r;
  // Status is built from next values and registered, so all bits but limiting keep the timing of their sources; limiting lags over by one cycle.
  assign status_nxt = '{limiting:    limiting_nxt,
                        torque_mode: method_nxt[7:4] == atcs_pkg::MODE_TORQUE,
                        editing:     st_nxt == atcs_pkg::ST_EDIT,
                        offset_done: done_nxt,
                        offset_busy: st_nxt == atcs_pkg::ST_AUTO};
  assign status     = status_r;

  sequence s_hold_open;
    (st_r == atcs_pkg::ST_IDLE) && held && !(auto_go && !servo_on);
  endsequence
  sequence s_enter;
    ##1 (st_r == atcs_pkg::ST_ENTER);
  endsequence

  a_pready_single: assert property (@(posedge clk) disable iff (rst)
    pready |=> !pready) else $error("pready held beyond one cycle");
  a_unmapped_err: assert property (@(posedge clk) disable iff (rst)
    acc && !hit |=> pready && pslverr) else $error("unmapped access without error");
  a_gain_range: assert property (@(posedge clk) disable iff (rst)
    tgain_r >= 16'h000A && tgain_r <= 16'h0064) else $error("torque gain out of range");
  a_limit_ceiling: assert property (@(posedge clk) disable iff (rst)
    ##1 lim_r <= $past(maxspd_r)) else $error("speed limit above motor maximum");
  a_nontorque_zero: assert property (@(posedge clk) disable iff (rst)
    trq_sample.valid && !trq_mode |=> torque_ref == 16'sh0000 && torque_ref_valid)
    else $error("torque output in non torque mode");
  a_auto_servo_off: assert property (@(posedge clk) disable iff (rst)
    auto_go && servo_on && st_r == atcs_pkg::ST_IDLE |=> st_r != atcs_pkg::ST_AUTO)
    else $error("auto offset started with servo on");
  a_edit_open: assert property (@(posedge clk) disable iff (rst)
    s_hold_open |-> s_enter) else $error("edit not opened after hold");
  a_done_wins: assert property (@(posedge clk) disable iff (rst)
    st_r == atcs_pkg::ST_AUTO && cnt_r[atcs_pkg::AUTO_LOG2] |=> done_r &&
    offset_r == $past(avg)) else $error("offset not stored");
  a_ref_follows: assert property (@(posedge clk) disable iff (rst)
    trq_sample.valid && trq_mode && !limiting_nxt |=> torque_ref == $past(raw))
    else $error("torque reference not proportional");
  a_overspeed_cut: assert property (@(posedge clk) disable iff (rst)
    trq_sample.valid && trq_mode && limiting_nxt && !motor_speed[15] && raw > 16'sh0000
    |=> torque_ref < $past(raw) || $past(fb) == 32'sh0000_0000)
    else $error("overspeed did not reduce torque");

endmodule
`default_nettype wire

// >>> bench/atcs_host_model.sv
// Host controller model that drives the torque and speed limit sample streams.
`timescale 1ns/1ps
`default_nettype none
module atcs_host_model #(
  parameter int unsigned PER = 8
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic signed [15:0] trq_mv,
  input  wire logic signed [15:0] lim_mv,
  output atcs_pkg::atcs_sample_t  trq_sample,
  output atcs_pkg::atcs_sample_t  lim_sample
);
  int unsigned cnt;

  // Samples are spaced PER cycles apart, each valid for one cycle.
  // Between samples the data lines flip to the inverse of their previous value every cycle, so a design that
  // reads them outside the valid pulse sees the inverse of the last value on alternate cycles and the value itself in between.
  always @(posedge clk) begin
    if (rst || cnt == PER - 1) begin
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
    if (!rst && cnt == PER - 1) begin
      trq_sample <= '{valid: 1'b1, mv: trq_mv};
      lim_sample <= '{valid: 1'b1, mv: lim_mv};
    end else begin
      trq_sample <= '{valid: 1'b0, mv: ~trq_sample.mv};
      lim_sample <= '{valid: 1'b0, mv: ~lim_sample.mv};
    end
  end
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking testbench of the analog torque command block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int unsigned HOLD = 20;
  logic                   clk          = 1'b0;
  logic                   rst          = 1'b1;
  logic                   psel         = 1'b0;
  logic                   penable      = 1'b0;
  logic                   pwrite       = 1'b0;
  logic [7:0]             paddr        = 8'h00;
  logic [31:0]            pwdata       = 32'h0000_0000;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic signed [15:0]     trq_mv       = 16'h0000;
  logic signed [15:0]     lim_mv       = 16'h0000;
  logic signed [15:0]     motor_speed  = 16'h0000;
  logic                   servo_on_pin = 1'b0;
  atcs_pkg::atcs_keys_t   keys_pin     = '0;
  atcs_pkg::atcs_sample_t trq_sample;
  atcs_pkg::atcs_sample_t lim_sample;
  logic signed [15:0]     torque_ref;
  logic                   torque_ref_valid;
  logic [15:0]            speed_limit;
  atcs_pkg::atcs_status_t status;
  int                     errors       = 0;
  int                     checks_done  = 0;
  logic [31:0]            rd;
  logic                   er;

  always #2 clk = ~clk;

  atcs_host_model atcs_host_model_i (.clk(clk), .rst(rst), .trq_mv(trq_mv), .lim_mv(lim_mv),
    .trq_sample(trq_sample), .lim_sample(lim_sample));

  atcs_top #(.HOLD_CYC(HOLD)) atcs_top_i (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trq_sample(trq_sample), .lim_sample(lim_sample),
    .motor_speed(motor_speed), .servo_on_pin(servo_on_pin), .keys_pin(keys_pin),
    .torque_ref(torque_ref), .torque_ref_valid(torque_ref_valid),
    .speed_limit(speed_limit), .status(status));

  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at time %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0000, wd};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    apb(1'b0, a, 16'h0000);
    chk(rd, {16'h0000, exp});
  endtask

  // The second sample after a change is the first one sure to carry the new voltage.
  task automatic trq(input logic signed [15:0] mv, input logic signed [15:0] exp);
    trq_mv <= mv;
    for (int k = 0; k < 2; k++) begin
      do begin
        @(posedge clk);
      end while (torque_ref_valid !== 1'b1);
    end
    chk({16'h0000, torque_ref}, {16'h0000, exp});
  endtask

  task automatic press(input logic [2:0] k, input int unsigned len);
    keys_pin <= k;
    repeat (len) @(posedge clk);
    keys_pin <= 3'b000;
    repeat (8) @(posedge clk);
  endtask

  localparam logic [7:0]  RA [6] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h28};
  localparam logic [15:0] RV [6] = '{16'h0020, 16'h001E, 16'h05DC, 16'h0096, 16'h1770, 16'h0010};
  localparam logic [3:0]  MD [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h8, 4'h9};

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) rdc(RA[i], RV[i]);
    chk({16'h0000, speed_limit}, 32'h0000_05DC);
    apb(1'b0, 8'h3C, 16'h0000);
    chk({31'h0, er}, 32'h0000_0001);
    wr(atcs_pkg::OFS_TRQ_GAIN, 16'h0005);
    rdc(atcs_pkg::OFS_TRQ_GAIN, 16'h000A);
    wr(atcs_pkg::OFS_TRQ_GAIN, 16'h00C8);
    rdc(atcs_pkg::OFS_TRQ_GAIN, 16'h0064);
    trq(16'h0BB8, 16'h012C);
    wr(atcs_pkg::OFS_TRQ_GAIN, 16'h001E);
    wr(atcs_pkg::OFS_SPD_LIM, 16'h1B58);
    rdc(atcs_pkg::OFS_SPD_LIM, 16'h1770);
    wr(atcs_pkg::OFS_SPD_GAIN, 16'h0FA0);
    rdc(atcs_pkg::OFS_SPD_GAIN, 16'h0BB8);
    wr(atcs_pkg::OFS_SPD_GAIN, 16'h0096);
    trq(16'h0BB8, 16'h03E8);
    trq(16'hFED4, 16'hFF9C);
    trq(16'h2328, 16'h0BB8);
    rdc(atcs_pkg::OFS_TRQ_MON, 16'h0BB8);
    for (int i = 0; i < 7; i++) begin
      wr(atcs_pkg::OFS_METHOD, {8'h00, MD[i], 4'h0});
      trq(16'h0BB8, (MD[i] inside {2, 6, 8, 9}) ? 16'h03E8 : 16'h0000);
      chk({31'h0, status.torque_mode}, {31'h0, MD[i] == 4'h2});
    end
    wr(atcs_pkg::OFS_METHOD, 16'h0020);
    wr(atcs_pkg::OFS_OFFSET, 16'h0064);
    trq(16'h0C1C, 16'h03E8);
    trq(16'h0032, 16'hFFF0);
    servo_on_pin <= 1'b0;
    wr(atcs_pkg::OFS_CMD, 16'h0001);
    do begin
      @(posedge clk);
    end while (status.offset_done !== 1'b1);
    rdc(atcs_pkg::OFS_OFFSET, 16'h0032);
    trq(16'h0BEA, 16'h03E8);
    wr(atcs_pkg::OFS_CMD, 16'h0002);
    repeat (2) @(posedge clk);
    chk({31'h0, status.offset_done}, 32'h0000_0000);
    servo_on_pin <= 1'b1;
    repeat (4) @(posedge clk);
    wr(atcs_pkg::OFS_CMD, 16'h0001);
    repeat (2) @(posedge clk);
    chk({31'h0, status.offset_busy}, 32'h0000_0000);
    servo_on_pin <= 1'b0;
    press(3'b100, HOLD + 10);
    chk({31'h0, status.editing}, 32'h0000_0001);
    press(3'b010, 4);
    press(3'b010, 4);
    press(3'b010, 4);
    press(3'b001, 4);
    press(3'b100, HOLD + 10);
    chk({31'h0, status.editing}, 32'h0000_0000);
    rdc(atcs_pkg::OFS_OFFSET, 16'h0002);
    wr(atcs_pkg::OFS_OFFSET, 16'h0000);
    wr(atcs_pkg::OFS_SPD_LIM, 16'h07D0);
    wr(atcs_pkg::OFS_MAX_SPD, 16'h0708);
    trq(16'h0BB8, 16'h03E8);
    chk({16'h0000, speed_limit}, 32'h0000_0708);
    lim_mv <= 16'hE890;
    wr(atcs_pkg::OFS_OPTION, 16'h0100);
    trq(16'h0BB8, 16'h03E8);
    chk({16'h0000, speed_limit}, 32'h0000_0384);
    motor_speed <= 16'h03E8;
    trq(16'h0BB8, 16'h0384);
    chk({31'h0, status.limiting}, 32'h0000_0001);
    motor_speed <= 16'hFC18;
    trq(16'hF448, 16'hFC7C);
    motor_speed <= 16'h0000;
    wr(atcs_pkg::OFS_OPTION, 16'h0000);
    trq(16'h0BB8, 16'h03E8);
    chk({16'h0000, speed_limit}, 32'h0000_0708);
    conclude();
  end

  initial begin
    #(4 * 40000);
    errors++;
    conclude();
  end
endmodule
`default_nettype wire
